// File: rtl/pkor_pkg.sv
// Shared constants and types of the packed operand register file.
// Assumes an APB master on the core clock and 12-bit byte addresses.
package pkor_pkg;
  // Register map, byte addresses
  localparam logic [11:0] A_XREG  = 12'h000;
  localparam logic [11:0] A_YREG  = 12'h080;
  localparam logic [11:0] A_CMD   = 12'h100;
  localparam logic [11:0] A_STAT  = 12'h104;
  localparam logic [11:0] A_FPCL  = 12'h108;
  localparam logic [11:0] A_FPSIG = 12'h10C;
  // Block select codes; code 0 is the absent prefix
  localparam logic [1:0] BLK_DFLT = 2'h0;
  localparam logic [1:0] BLK_X    = 2'h1;
  localparam logic [1:0] BLK_Y    = 2'h2;
  // Register group width codes
  localparam logic [1:0] WD_SGL  = 2'h0;
  localparam logic [1:0] WD_DBL  = 2'h1;
  localparam logic [1:0] WD_QUAD = 2'h2;
  // Lane size codes
  localparam logic [1:0] LN_NORM  = 2'h0;
  localparam logic [1:0] LN_BYTE  = 2'h1;
  localparam logic [1:0] LN_SHORT = 2'h2;
  localparam logic [1:0] LN_LONG  = 2'h3;
  // Operation codes
  localparam logic [2:0] OP_ADD  = 3'h0;
  localparam logic [2:0] OP_SUB  = 3'h1;
  localparam logic [2:0] OP_AND  = 3'h2;
  localparam logic [2:0] OP_OR   = 3'h3;
  localparam logic [2:0] OP_XOR  = 3'h4;
  // Floating-point constants
  localparam logic [7:0] FP_EXP_ONES = 8'hFF;
  localparam logic [8:0] FP_BIAS     = 9'h07F;
  typedef struct packed {
    logic [5:0] rsv;
    logic [4:0] n;
    logic [4:0] m;
    logic [4:0] d;
    logic [2:0] op;
    logic       sgn;
    logic       fp;
    logic [1:0] lane;
    logic [1:0] width;
    logic [1:0] blk;
  } pkor_cmd_t;
  typedef struct packed {
    logic [25:0] rsv;
    logic        ovf_y;
    logic        ovf_x;
    logic        e_same;
    logic        e_size;
    logic        e_align;
    logic        done;
  } pkor_stat_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pkor_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } pkor_apb_rsp_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RD_M, ST_RD_N, ST_EXEC, ST_AP_WAIT
  } pkor_state_t;
endpackage

// File: rtl/pkor_rf.sv
// Thirty-two 32-bit data registers of one compute block.
// One quad-aligned port; read data registered, writes by word mask.
`timescale 1ns/1ns
`default_nettype none
module pkor_rf (
  input  wire logic         mclk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [2:0]   addr_i,
  input  wire logic [3:0]   we_i,
  input  wire logic [127:0] wd_i,
  output logic      [127:0] rd_o
);
  typedef struct packed {
    logic [31:0][31:0] mem;
    logic [127:0]      rd;
  } pkor_rf_st_t;
  pkor_rf_st_t r_r;
  pkor_rf_st_t r_nxt;
  // Read returns old contents when a word is written in the same cycle
  always_comb begin
    r_nxt = r_r;
    for (int i = 0; i < 4; i++) begin
      r_nxt.rd[i*32 +: 32] = r_r.mem[{addr_i, 2'(i)}];
      if (we_i[i]) begin
        r_nxt.mem[{addr_i, 2'(i)}] = wd_i[i*32 +: 32];
      end
    end
  end
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end
  assign rd_o = r_r.rd;
endmodule // pkor_rf
`default_nettype wire

// File: rtl/pkor_lane_alu.sv
// One 32-bit word slice of the lane-partitioned ALU.
// Purely combinational; slices chain by cin/cout only in long lanes.
`timescale 1ns/1ns
`default_nettype none
module pkor_lane_alu (
  input  wire logic [31:0] a_i,
  input  wire logic [31:0] b_i,
  input  wire logic [2:0]  op_i,
  input  wire logic [1:0]  lane_i,
  input  wire logic        sgn_i,
  input  wire logic        cin_i,
  output logic      [31:0] y_o,
  output logic             cout_o,
  output logic             ovf_o
);
  // Byte-wise ripple; lane starts inject the fresh carry, so no carry
  // leaks across a lane edge
  always_comb begin
    logic       sub;
    logic       c;
    logic       first;
    logic       last;
    logic       arith;
    logic [7:0] bb;
    logic [8:0] s;
    sub   = (op_i == pkor_pkg::OP_SUB);
    arith = sub || (op_i == pkor_pkg::OP_ADD);
    c     = cin_i;
    first = 1'b0;
    last  = 1'b0;
    bb    = 8'h00;
    s     = 9'h000;
    y_o   = 32'h0000_0000;
    ovf_o = 1'b0;
    for (int k = 0; k < 4; k++) begin
      bb = sub ? ~b_i[k*8 +: 8] : b_i[k*8 +: 8];
      first = (lane_i == pkor_pkg::LN_BYTE) ||
              (lane_i == pkor_pkg::LN_SHORT && (k % 2) == 0) ||
              (k == 0 && lane_i != pkor_pkg::LN_LONG);
      last  = (lane_i == pkor_pkg::LN_BYTE) ||
              (lane_i == pkor_pkg::LN_SHORT && (k % 2) == 1) || (k == 3);
      s = {1'b0, a_i[k*8 +: 8]} + {1'b0, bb} + {8'h00, first ? sub : c};
      c = s[8];
      case (op_i)
        pkor_pkg::OP_ADD, pkor_pkg::OP_SUB: y_o[k*8 +: 8] = s[7:0];
        pkor_pkg::OP_AND: y_o[k*8 +: 8] = a_i[k*8 +: 8] & b_i[k*8 +: 8];
        pkor_pkg::OP_OR:  y_o[k*8 +: 8] = a_i[k*8 +: 8] | b_i[k*8 +: 8];
        pkor_pkg::OP_XOR: y_o[k*8 +: 8] = a_i[k*8 +: 8] ^ b_i[k*8 +: 8];
        default:          y_o[k*8 +: 8] = a_i[k*8 +: 8];
      endcase
      // Signed: sign flip; unsigned: carry out or borrow
      if (last && arith) begin
        ovf_o = ovf_o | (sgn_i ? ((a_i[k*8+7] == bb[7]) &&
                                  (s[7] != a_i[k*8+7]))
                               : (s[8] ^ sub));
      end
    end
    cout_o = c;
  end
endmodule // pkor_lane_alu
`default_nettype wire

// File: rtl/pkor_top.sv
// Packed operand register file: X and Y data registers, lane ALU,
// command sequencer and APB slave for registers and commands.
// Assumes an APB master on mclk_i and a synchronous reset.
`timescale 1ns/1ns
`default_nettype none
module pkor_top (
  input  wire logic                    mclk_i,
  input  wire logic                    sys_rst_i,
  input  wire pkor_pkg::pkor_apb_req_t apb_req_i,
  output var  pkor_pkg::pkor_apb_rsp_t apb_rsp_o
);
  typedef struct packed {
    pkor_pkg::pkor_state_t   state;
    pkor_pkg::pkor_cmd_t     cmd;
    logic [1:0][127:0]       opm;
    pkor_pkg::pkor_stat_t    stat;
    logic [31:0]             fpcl;
    logic [31:0]             fpsig;
    pkor_pkg::pkor_apb_rsp_t rsp;
  } pkor_top_st_t;

  pkor_top_st_t      st_r;
  pkor_top_st_t      st_nxt;
  logic [2:0]        rf_addr;
  logic [1:0][3:0]   rf_we;
  logic [1:0][127:0] rf_wd;
  logic [1:0][127:0] rf_rd;
  logic [1:0][127:0] opn;
  logic [1:0][127:0] alu_y;
  logic [1:0][3:0]   alu_c;
  logic [1:0][3:0]   alu_v;
  logic [1:0]        blk_en;
  logic [3:0]        wm;
  logic [3:0]        wm_d;
  logic              is_data;
  logic              mapped;
  logic              acc;
  logic              fin;
  logic              sub;
  logic              lng;

  // Keep the words of a group, starting at the named register
  function automatic logic [127:0] pick_words(input logic [127:0] q,
                                              input logic [1:0]   w,
                                              input logic [3:0]   msk);
    logic [127:0] s;
    s = q >> {w, 5'h00};
    for (int i = 0; i < 4; i++) begin
      if (!msk[i]) begin
        s[i*32 +: 32] = 32'h0000_0000;
      end
    end
    return s;
  endfunction

  // Bus decode; data registers fill the low 256 bytes
  assign is_data = (apb_req_i.paddr[11:8] == 4'h0);
  assign mapped  = is_data || (apb_req_i.paddr == pkor_pkg::A_CMD) ||
                   (apb_req_i.paddr == pkor_pkg::A_STAT) ||
                   (apb_req_i.paddr == pkor_pkg::A_FPCL) ||
                   (apb_req_i.paddr == pkor_pkg::A_FPSIG);
  assign acc = apb_req_i.psel && apb_req_i.penable;
  assign fin = acc && st_r.rsp.pready;
  assign sub = (st_r.cmd.op == pkor_pkg::OP_SUB);
  assign lng = (st_r.cmd.lane == pkor_pkg::LN_LONG);

  // Absent prefix behaves as both blocks
  assign blk_en[0] = (st_r.cmd.blk != pkor_pkg::BLK_Y);
  assign blk_en[1] = (st_r.cmd.blk != pkor_pkg::BLK_X);

  // Word mask of the group, and the same mask at the destination
  always_comb begin
    case (st_r.cmd.width)
      pkor_pkg::WD_SGL: wm = 4'h1;
      pkor_pkg::WD_DBL: wm = 4'h3;
      default:          wm = 4'hF;
    endcase
    wm_d = 4'(wm << st_r.cmd.d[1:0]);
  end

  // Two blocks, four word slices each; no path between the blocks
  for (genvar b = 0; b < 2; b++) begin : g_blk
    pkor_rf u_rf (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .addr_i    (rf_addr),
      .we_i      (rf_we[b]),
      .wd_i      (rf_wd[b]),
      .rd_o      (rf_rd[b])
    );
    assign opn[b] = pick_words(rf_rd[b], st_r.cmd.n[1:0], wm);
    for (genvar w = 0; w < 4; w++) begin : g_word
      logic cin;
      if (w % 2 == 1) begin : g_odd
        assign cin = lng ? alu_c[b][w-1] : sub;
      end else begin : g_even
        assign cin = sub;
      end
      pkor_lane_alu u_alu (
        .a_i    (st_r.opm[b][w*32 +: 32]),
        .b_i    (opn[b][w*32 +: 32]),
        .op_i   (st_r.cmd.op),
        .lane_i (st_r.cmd.lane),
        .sgn_i  (st_r.cmd.sgn),
        .cin_i  (cin),
        .y_o    (alu_y[b][w*32 +: 32]),
        .cout_o (alu_c[b][w]),
        .ovf_o  (alu_v[b][w])
      );
    end
  end

  // Sequencer, bus answers and floating-point classification
  always_comb begin
    pkor_pkg::pkor_cmd_t c;
    logic [127:0] res;
    logic [63:0]  fw;
    logic         sgn;
    logic [7:0]   ex;
    logic [30:0]  man;
    logic         norm;
    logic [8:0]   tex;
    logic         arith;
    c      = pkor_pkg::pkor_cmd_t'(apb_req_i.pwdata);
    res    = 128'h0;
    fw     = 64'h0;
    sgn    = 1'b0;
    ex     = 8'h00;
    man    = 31'h0;
    norm   = 1'b0;
    tex    = 9'h000;
    arith  = (st_r.cmd.op == pkor_pkg::OP_ADD) || sub;
    st_nxt = st_r;
    st_nxt.rsp.pready  = 1'b0;
    st_nxt.rsp.pslverr = 1'b0;
    rf_addr = apb_req_i.paddr[6:4];
    rf_we   = '0;
    rf_wd   = '0;
    case (st_r.state)
      pkor_pkg::ST_IDLE: begin
        if (fin && apb_req_i.pwrite && is_data) begin
          // Bus write lands at the completing edge
          rf_we[apb_req_i.paddr[7]] = 4'(4'h1 << apb_req_i.paddr[3:2]);
          rf_wd[apb_req_i.paddr[7]] = {4{apb_req_i.pwdata}};
        end else if (fin && apb_req_i.pwrite &&
                     apb_req_i.paddr == pkor_pkg::A_CMD) begin
          st_nxt.cmd = c;
          st_nxt.stat = '0;
          st_nxt.stat.e_align =
            (c.width == pkor_pkg::WD_DBL && (c.m[0] | c.n[0] | c.d[0])) ||
            (c.width == pkor_pkg::WD_QUAD &&
             ((c.m[1:0] | c.n[1:0] | c.d[1:0]) != 2'h0));
          st_nxt.stat.e_size = (c.width == 2'h3) ||
            (c.lane == pkor_pkg::LN_LONG && c.width == pkor_pkg::WD_SGL);
          st_nxt.stat.e_same =
            (c.width == pkor_pkg::WD_DBL) && (c.m == c.n);
          if (!(st_nxt.stat.e_align || st_nxt.stat.e_size ||
                st_nxt.stat.e_same)) begin
            st_nxt.state = pkor_pkg::ST_RD_M;
          end
        end else if (acc && !st_r.rsp.pready) begin
          if (is_data && !apb_req_i.pwrite) begin
            st_nxt.state = pkor_pkg::ST_AP_WAIT;
          end else begin
            st_nxt.rsp.pready  = 1'b1;
            st_nxt.rsp.pslverr = !mapped;
            case (apb_req_i.paddr)
              pkor_pkg::A_CMD:   st_nxt.rsp.prdata = st_r.cmd;
              pkor_pkg::A_STAT:  st_nxt.rsp.prdata = st_r.stat;
              pkor_pkg::A_FPCL:  st_nxt.rsp.prdata = st_r.fpcl;
              pkor_pkg::A_FPSIG: st_nxt.rsp.prdata = st_r.fpsig;
              default:           st_nxt.rsp.prdata = 32'h0000_0000;
            endcase
          end
        end
      end
      pkor_pkg::ST_AP_WAIT: begin
        st_nxt.rsp.pready = 1'b1;
        st_nxt.rsp.prdata =
          rf_rd[apb_req_i.paddr[7]][apb_req_i.paddr[3:2]*32 +: 32];
        st_nxt.state = pkor_pkg::ST_IDLE;
      end
      pkor_pkg::ST_RD_M: begin
        rf_addr = st_r.cmd.m[4:2];
        st_nxt.state = pkor_pkg::ST_RD_N;
      end
      pkor_pkg::ST_RD_N: begin
        rf_addr = st_r.cmd.n[4:2];
        for (int b = 0; b < 2; b++) begin
          st_nxt.opm[b] = pick_words(rf_rd[b], st_r.cmd.m[1:0], wm);
        end
        st_nxt.state = pkor_pkg::ST_EXEC;
      end
      pkor_pkg::ST_EXEC: begin
        rf_addr = st_r.cmd.d[4:2];
        // Every block enabled by blk_en writes in this one cycle
        for (int b = 0; b < 2; b++) begin
          if (st_r.cmd.fp) begin
            res = st_r.opm[b];
            if (st_r.cmd.width == pkor_pkg::WD_DBL) begin
              res[63:40] = 24'h00_0000;
            end
          end else begin
            res = alu_y[b];
          end
          if (blk_en[b]) begin
            rf_we[b] = wm_d;
            rf_wd[b] = res << {st_r.cmd.d[1:0], 5'h00};
          end
        end
        st_nxt.stat.ovf_x = blk_en[0] && arith && !st_r.cmd.fp &&
                            |(alu_v[0] & wm & (lng ? 4'hA : 4'hF));
        st_nxt.stat.ovf_y = blk_en[1] && arith && !st_r.cmd.fp &&
                            |(alu_v[1] & wm & (lng ? 4'hA : 4'hF));
        st_nxt.stat.done = 1'b1;
        // Classify operand m of the first selected block
        if (st_r.cmd.fp) begin
          fw = blk_en[0] ? st_r.opm[0][63:0] : st_r.opm[1][63:0];
          if (st_r.cmd.width == pkor_pkg::WD_DBL) begin
            sgn = fw[39];
            ex  = fw[38:31];
            man = fw[30:0];
          end else begin
            sgn = fw[31];
            ex  = fw[30:23];
            man = {fw[22:0], 8'h00};
          end
          norm = (ex != 8'h00) && (ex != pkor_pkg::FP_EXP_ONES);
          tex  = {1'b0, ex} - pkor_pkg::FP_BIAS;
          st_nxt.fpcl = {7'h00, tex, ex, 2'h0, norm, sgn,
                         (ex == 8'h00) && (man == 31'h0), norm,
                         (ex == pkor_pkg::FP_EXP_ONES) && (man == 31'h0),
                         (ex == pkor_pkg::FP_EXP_ONES) && (man != 31'h0)};
          st_nxt.fpsig = {norm, man};
        end
        st_nxt.state = pkor_pkg::ST_IDLE;
      end
      default: st_nxt.state = pkor_pkg::ST_IDLE;
    endcase
  end

  // Every output is taken straight from this register
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign apb_rsp_o = st_r.rsp;

  // Checks on the sequencer and the datapath
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  logic cmd_go;
  assign cmd_go = (st_r.state == pkor_pkg::ST_IDLE) && fin &&
                  apb_req_i.pwrite && (apb_req_i.paddr == pkor_pkg::A_CMD);
  sequence s_reads;
    st_r.state == pkor_pkg::ST_RD_M ##1 st_r.state == pkor_pkg::ST_RD_N
    ##1 st_r.state == pkor_pkg::ST_EXEC ##1 st_r.state == pkor_pkg::ST_IDLE;
  endsequence

  cmd_runs_a: assert property (cmd_go && !st_nxt.stat.e_align &&
    !st_nxt.stat.e_size && !st_nxt.stat.e_same |=> s_reads)
    else $error("command did not run its read and execute steps");
  dbl_align_a: assert property (
    cmd_go && apb_req_i.pwdata[3:2] == 2'h1 &&
    (apb_req_i.pwdata[11] | apb_req_i.pwdata[16] | apb_req_i.pwdata[21])
    |=> st_r.stat.e_align && !st_r.stat.done)
    else $error("odd double base not refused");
  quad_align_a: assert property (
    cmd_go && apb_req_i.pwdata[3:2] == 2'h2 &&
    (apb_req_i.pwdata[12:11] | apb_req_i.pwdata[17:16] |
     apb_req_i.pwdata[22:21]) != 2'h0 |=>
    st_r.stat.e_align && st_r.state == pkor_pkg::ST_IDLE)
    else $error("unaligned quad base not refused");
  same_src_a: assert property (
    cmd_go && apb_req_i.pwdata[3:2] == 2'h1 &&
    apb_req_i.pwdata[20:16] == apb_req_i.pwdata[25:21] |=> st_r.stat.e_same)
    else $error("double with equal sources not refused");
  byte_lane_a: assert property (st_r.state == pkor_pkg::ST_EXEC &&
    st_r.cmd.lane == pkor_pkg::LN_BYTE && st_r.cmd.op == pkor_pkg::OP_ADD
    |-> alu_y[0][15:8] == 8'(st_r.opm[0][15:8] + opn[0][15:8]))
    else $error("byte lane result wrong");
  short_lane_a: assert property (st_r.state == pkor_pkg::ST_EXEC &&
    st_r.cmd.lane == pkor_pkg::LN_SHORT && st_r.cmd.op == pkor_pkg::OP_SUB
    |-> alu_y[1][31:16] == 16'(st_r.opm[1][31:16] - opn[1][31:16]))
    else $error("short lane borrow crossed a lane");
  long_lane_a: assert property (st_r.state == pkor_pkg::ST_EXEC && lng &&
    st_r.cmd.op == pkor_pkg::OP_ADD |->
    alu_y[0][63:0] == 64'(st_r.opm[0][63:0] + opn[0][63:0]))
    else $error("long lane carry not joined");
  both_blk_a: assert property (st_r.state == pkor_pkg::ST_EXEC &&
    st_r.cmd.blk == pkor_pkg::BLK_DFLT |-> rf_we[0] == wm_d && rf_we[1] == wm_d)
    else $error("both blocks not written together");
  ext_upper_a: assert property (st_r.state == pkor_pkg::ST_EXEC &&
    st_r.cmd.fp && st_r.cmd.width == pkor_pkg::WD_DBL && rf_we[0] != 4'h0
    |-> rf_wd[0][st_r.cmd.d[1:0]*32+40 +: 24] == 24'h00_0000)
    else $error("extended upper bits not cleared");
  fp_nan_a: assert property (st_r.state == pkor_pkg::ST_EXEC && st_r.cmd.fp &&
    blk_en[0] && st_r.cmd.width == pkor_pkg::WD_SGL &&
    st_r.opm[0][30:23] == 8'hFF && st_r.opm[0][22:0] != 23'h0
    |=> st_r.fpcl[0] && !st_r.fpcl[1] && !st_r.fpsig[31])
    else $error("not-a-number code misclassified");
  bus_ready_a: assert property (acc && !st_r.rsp.pready &&
    st_r.state == pkor_pkg::ST_IDLE |-> ##[1:2] st_r.rsp.pready)
    else $error("bus access not answered in two cycles");
endmodule // pkor_top
`default_nettype wire

// File: verification/pkor_apb_mst.sv
// APB master standing in for the instruction decoder side.
// Assumes one request at a time, started by a one-cycle go pulse.
`timescale 1ns/1ns
`default_nettype none
module pkor_apb_mst (
  input  wire logic                    mclk_i,
  input  wire logic                    sys_rst_i,
  input  wire logic                    go_i,
  input  wire logic                    wr_i,
  input  wire logic [11:0]             addr_i,
  input  wire logic [31:0]             wd_i,
  input  wire pkor_pkg::pkor_apb_rsp_t rsp_i,
  output var  pkor_pkg::pkor_apb_req_t req_o = '0,
  output logic      [31:0]             rd_o = '0,
  output logic                         err_o = 1'b0,
  output logic                         done_o = 1'b0
);
  // Setup, then access held until pready; released bus shows junk
  always @(posedge mclk_i) begin
    done_o <= 1'b0;
    if (sys_rst_i) begin
      req_o <= '0;
    end else if (go_i) begin
      req_o <= '{1'b1, 1'b0, wr_i, addr_i, wd_i};
    end else if (req_o.psel && !req_o.penable) begin
      req_o.penable <= 1'b1;
    end else if (req_o.penable && rsp_i.pready) begin
      req_o  <= '{1'b0, 1'b0, 1'b0, ~req_o.paddr, ~req_o.pwdata};
      rd_o   <= rsp_i.prdata;
      err_o  <= rsp_i.pslverr;
      done_o <= 1'b1;
    end
  end
endmodule // pkor_apb_mst
`default_nettype wire

// File: verification/packed_operand_register_file_tb_top.sv
// Self-checking bench: integer model of both register files.
// Assumes pkor_top answers every APB access within 50 cycles.
`timescale 1ns/1ns
`default_nettype none
module packed_operand_register_file_tb_top;
  logic                    mclk_i = 1'b0;
  logic                    sys_rst_i = 1'b1;
  logic                    go = 1'b0;
  logic                    wr = 1'b0;
  logic [11:0]             ad = '0;
  logic [31:0]             wd = '0;
  logic [31:0]             rd;
  logic                    err, done;
  pkor_pkg::pkor_apb_req_t req;
  pkor_pkg::pkor_apb_rsp_t rsp;
  logic [31:0]             mdl [2][32];
  integer n_errors = 0, num_checks = 0, seed = 44, cyc = 0;

  pkor_top dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .apb_req_i(req), .apb_rsp_o(rsp));
  pkor_apb_mst mst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .go_i(go),
    .wr_i(wr), .addr_i(ad), .wd_i(wd), .rsp_i(rsp), .req_o(req),
    .rd_o(rd), .err_o(err), .done_o(done));

  // Clock and hang guard
  initial forever #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc >= 20000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // One APB transfer; waits for the answer, not a fixed count
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge mclk_i);
    go <= 1'b1; wr <= w; ad <= a; wd <= d;
    @(posedge mclk_i);
    go <= 1'b0;
    for (k = 0; k < 50 && !done; k++) begin
      @(posedge mclk_i); #1;
    end
    // A missing answer counts as a mismatch and ends the run
    if (!done) begin
      n_errors++;
      close_out();
    end
  endtask

  function automatic logic [11:0] ra(input int b, input int i);
    return (b != 0 ? pkor_pkg::A_YREG : pkor_pkg::A_XREG) + 12'(i * 4);
  endfunction

  // Lanes computed apart, so no carry leaks between them
  function automatic logic [127:0] lane_op(input logic [127:0] a, b,
                                           input int lw, logic [2:0] op);
    logic [127:0] r, msk, x, y, z;
    r = '0;
    msk = (128'h1 << lw) - 1;
    for (int i = 0; i < 128 / lw; i++) begin
      x = (a >> (i * lw)) & msk;
      y = (b >> (i * lw)) & msk;
      case (op)
        3'h0: z = x + y;
        3'h1: z = x - y;
        3'h2: z = x & y;
        3'h3: z = x | y;
        3'h4: z = x ^ y;
        default: z = x;
      endcase
      r |= (z & msk) << (i * lw);
    end
    return r;
  endfunction

  // Overflow of any lane: sign flip if signed, carry or borrow if not
  function automatic logic lane_ovf(input logic [127:0] a, b,
                                    input int lw, input logic sb, sg);
    logic [127:0] x, y, z, msk;
    logic v;
    v = 1'b0;
    msk = (128'h1 << lw) - 1;
    for (int i = 0; i < 128 / lw; i++) begin
      x = (a >> (i * lw)) & msk;
      y = (b >> (i * lw)) & msk;
      z = sb ? x - y : x + y;
      if (sg) begin
        v |= (x[lw-1] == (y[lw-1] ^ sb)) && (z[lw-1] != x[lw-1]);
      end else begin
        v |= sb ? (x < y) : z[lw];
      end
    end
    return v;
  endfunction

  // Issue a command, update the model, check status and both blocks
  task automatic cmd(input logic [1:0] blk, w, ln, input logic fp,
                     input logic [2:0] op, input logic [4:0] d, m, n);
    pkor_pkg::pkor_cmd_t c;
    logic [127:0] a, b2, r;
    logic al, sz, sm, ok;
    logic [1:0] ov;
    int nw, lw, bk, i;
    c = '0; c.blk = blk; c.width = w; c.lane = ln; c.fp = fp;
    c.op = op; c.d = d; c.m = m; c.n = n;
    c.sgn = 1'($random(seed));
    a = '0;
    b2 = '0;
    ov = 2'h0;
    nw = (w == 2'h0) ? 1 : (w == 2'h1) ? 2 : 4;
    lw = ln == 2'h1 ? 8 : ln == 2'h2 ? 16 : ln == 2'h3 ? 64 : 32;
    al = (d % nw) != 0 || (m % nw) != 0 || (n % nw) != 0;
    sz = w == 2'h3 || lw > nw * 32;
    sm = w == 2'h1 && m == n;
    ok = !(al || sz || sm);
    apb(1'b1, pkor_pkg::A_CMD, c);
    if (!(al || sz || sm)) for (bk = 0; bk < 2; bk++)
      if (blk == 2'h0 || blk == 2'h3 || blk == 2'(bk + 1)) begin
        for (i = 0; i < nw; i++) begin
          a[i*32+:32] = mdl[bk][m+i];
          b2[i*32+:32] = mdl[bk][n+i];
        end
        r = fp ? a : lane_op(a, b2, lw, op);
        if (!fp && op < 3'h2) ov[bk] = lane_ovf(a, b2, lw, op[0], c.sgn);
        if (fp && nw == 2) r[63:40] = '0;
        for (i = 0; i < nw; i++) mdl[bk][d+i] = r[i*32+:32];
      end
    apb(1'b0, pkor_pkg::A_STAT, '0);
    chk(rd & 32'hF, {28'h0, sm, sz, al, ok});
    chk({30'h0, rd[5:4]}, {30'h0, ov});
    for (bk = 0; bk < 2; bk++)
      for (i = 0; i < nw; i++) begin
        apb(1'b0, ra(bk, d + i), '0);
        chk(rd, mdl[bk][d+i]);
      end
  endtask

  function automatic logic [31:0] fpcl(input logic [31:0] v);
    logic [7:0] e;
    logic nm;
    e = v[30:23];
    nm = e != 8'h00 && e != 8'hFF;
    return {7'h00, {1'b0, e} - 9'h07F, e, 2'h0, nm, v[31],
            e == 8'h00 && v[22:0] == '0, nm,
            e == 8'hFF && v[22:0] == '0, e == 8'hFF && v[22:0] != '0};
  endfunction

  initial begin
    logic [31:0] fv [7];
    logic [31:0] fc;
    logic [39:0] ew;
    int b, i, w, ln;
    fv = '{32'h7FC0_0000, 32'hFF80_0000, 32'h3F80_0000, 32'h8000_0000,
           32'h0000_0001, 32'h7F7F_FFFF, 32'h0080_0000};
    for (b = 0; b < 2; b++) for (i = 0; i < 32; i++) mdl[b][i] = '0;
    repeat (20) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    // Fill and read back every register of both blocks
    for (b = 0; b < 2; b++) for (i = 0; i < 32; i++) begin
      mdl[b][i] = $random(seed);
      apb(1'b1, ra(b, i), mdl[b][i]);
    end
    for (b = 0; b < 2; b++) for (i = 0; i < 32; i++) begin
      apb(1'b0, ra(b, i), '0);
      chk(rd, mdl[b][i]);
    end
    apb(1'b1, 12'h110, 32'h0000_0001);
    chk({31'h0, err}, 32'h0000_0001);
    $display("test registers finished");
    // Every width, lane size and block select with random ops
    for (w = 0; w < 3; w++) for (ln = 0; ln < 4; ln++)
      for (b = 0; b < 4; b++) if (!(w == 0 && ln == 3))
        cmd(2'(b), 2'(w), 2'(ln), 1'b0, 3'($unsigned($random(seed)) % 8),
            5'd8, 5'd16, 5'd20);
    $display("test lanes finished");
    // Refused groupings leave both files untouched
    cmd(2'h0, 2'h1, 2'h0, 1'b0, 3'h0, 5'd9, 5'd16, 5'd20);
    cmd(2'h0, 2'h2, 2'h0, 1'b0, 3'h0, 5'd8, 5'd18, 5'd20);
    cmd(2'h0, 2'h3, 2'h0, 1'b0, 3'h0, 5'd8, 5'd16, 5'd20);
    cmd(2'h0, 2'h0, 2'h3, 1'b0, 3'h0, 5'd8, 5'd16, 5'd20);
    cmd(2'h0, 2'h1, 2'h0, 1'b0, 3'h0, 5'd8, 5'd16, 5'd16);
    $display("test refusals finished");
    // Float classification of single values
    for (i = 0; i < 7; i++) begin
      mdl[0][4] = fv[i];
      apb(1'b1, ra(0, 4), fv[i]);
      cmd(2'h1, 2'h0, 2'h0, 1'b1, 3'h0, 5'd6, 5'd4, 5'd5);
      fc = fpcl(fv[i]);
      apb(1'b0, pkor_pkg::A_FPCL, '0);
      chk(rd, fc);
      apb(1'b0, pkor_pkg::A_FPSIG, '0);
      chk(rd, {fc[5], fv[i][22:0], 8'h00});
    end
    cmd(2'h0, 2'h1, 2'h0, 1'b1, 3'h0, 5'd10, 5'd4, 5'd6);
    // Extended value: sign at 39, 31-bit mantissa below the exponent
    ew = {mdl[0][5][7:0], mdl[0][4]};
    fc = {ew[38:31] != 8'h00 && ew[38:31] != 8'hFF, ew[30:0]};
    apb(1'b0, pkor_pkg::A_FPSIG, '0);
    chk(rd, fc);
    $display("test float finished");
    close_out();
  end
endmodule // packed_operand_register_file_tb_top
`default_nettype wire
